// [design/wsc_pkg.sv]
/*
 * wsc_pkg: shared constants and types of the weigh setpoint compare block.
 * Assumes a 32-bit APB register bus and signed weights from same-clock logic.
 */
package wsc_pkg;
    // ------------------------------------------------------------
    // widths and ranges
    // ------------------------------------------------------------
    localparam int WW = 24;                        // weight width
    localparam int CW = 8;                         // counter fields
    localparam logic [WW-1:0] SET_MAX = 24'h01_869F; // 99999
    typedef logic signed [WW-1:0] wsc_wt_t;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_SET_FIRST = 8'h04;  // first set value word
    localparam logic [7:0] OFS_FREE_FALL = 8'h28;
    localparam logic [7:0] OFS_AVG_COUNT = 8'h2C;
    localparam logic [7:0] OFS_JUDGE_INT = 8'h30;
    localparam logic [7:0] OFS_STATUS    = 8'h34;

    // set value array indices (offset = OFS_SET_FIRST + 4*index)
    localparam int IDX_FINAL  = 0;
    localparam int IDX_COARSE = 1;
    localparam int IDX_MEDIUM = 2;
    localparam int IDX_OVER   = 3;
    localparam int IDX_UNDER  = 4;
    localparam int IDX_NZ     = 5;
    localparam int IDX_UPPER  = 6;
    localparam int IDX_LOWER  = 7;
    localparam int IDX_REGUL  = 8;
    localparam int NSET       = 9;

    // ------------------------------------------------------------
    // selector codes
    // ------------------------------------------------------------
    localparam logic [2:0] SRC_GROSS     = 3'h0;
    localparam logic [2:0] SRC_NET       = 3'h1;
    localparam logic [2:0] SRC_OFF       = 3'h2;
    localparam logic [2:0] SRC_ABS_GROSS = 3'h3;
    localparam logic [2:0] SRC_ABS_NET   = 3'h4;
    localparam logic [1:0] OU_ALWAYS     = 2'h0;
    localparam logic [1:0] OU_JUDGE      = 2'h1;
    localparam logic [1:0] OU_COMPLETE   = 2'h2;
    localparam logic [1:0] OU_HOLD       = 2'h3;

    // control word, resets to zero
    typedef struct packed {
        logic [1:0] ou_mode;
        logic [1:0] ou_src;
        logic [2:0] nz_src;
        logic       ul_judge;   // 1: limits only while judge input on, outside sequence mode
        logic [1:0] ul_src;
        logic [1:0] coef;       // 0..3 -> 1/4 .. 4/4
        logic       auto_jog;
        logic       seq_mode;
    } wsc_ctrl_t;
    localparam wsc_ctrl_t CTRL_RESET = '0;

    // output flag group
    typedef struct packed {
        logic seq_error;
        logic lower;
        logic upper;
        logic near_zero;
        logic over;
        logic go;
        logic under;
        logic final_cut_point;
        logic medium_cut_point;
        logic coarse_cut_point;
    } wsc_flags_t;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_ERR} wsc_seq_t;
endpackage

// [design/wsc_ffc.sv]
/*
 * wsc_ffc: free-fall compensation accumulator and corrector.
 * Assumes sample_en pulses once per judged completion.
 */
`timescale 1ns/100ps
`default_nettype none
module wsc_ffc (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    // sample side
    input  wire logic              sample_en,
    input  wire wsc_pkg::wsc_wt_t  weight,
    input  wire wsc_pkg::wsc_wt_t  final_target,
    input  wire wsc_pkg::wsc_wt_t  regulation,
    input  wire logic [7:0]        avg_count,
    input  wire logic [1:0]        coef,
    // host write
    input  wire logic              ff_write,
    input  wire wsc_pkg::wsc_wt_t  ff_wdata,
    // state
    output logic [wsc_pkg::WW-1:0] free_fall_value,
    output logic [7:0]             sample_count
);
    logic signed [31:0] sum;
    logic signed [31:0] next_sum;
    logic        [7:0]  next_count;
    logic        [23:0] next_ff;
    logic signed [31:0] err;
    logic signed [39:0] num;
    logic        [39:0] mag;
    logic        [39:0] den;
    logic        [39:0] quo;
    logic               inwin;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        err = 32'(weight) - 32'(final_target);
        inwin = (err <= 32'(regulation)) && (err >= -32'(regulation));
        // coefficient as quarters; round half away from zero
        num  = 40'(err + sum) * $signed({38'h0, coef} + 40'h1);
        mag  = num[39] ? 40'(-num) : num;
        den  = {30'h0, avg_count, 2'b00};
        quo  = (den == 40'h0) ? 40'h0 : (mag + (den >> 1)) / den;
        next_sum   = sum;
        next_count = sample_count;
        next_ff    = free_fall_value;
        // error taken as weight minus final
        if (sample_en && inwin && avg_count != 8'h00) begin
            if (sample_count + 8'h01 >= avg_count) begin
                next_ff    = free_fall_value + (num[39] ? 24'(-quo) : 24'(quo));
                next_sum   = 32'h0;
                next_count = 8'h00;
            end else begin
                next_sum   = sum + err;
                next_count = sample_count + 8'h01;
            end
        end
        if (ff_write) begin
            next_ff    = ff_wdata;
            next_sum   = 32'h0;
            next_count = 8'h00;
        end
    end

    // registers only
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sum             <= 32'h0;
            sample_count    <= 8'h00;
            free_fall_value <= 24'h0;
        end else begin
            sum             <= next_sum;
            sample_count    <= next_count;
            free_fall_value <= next_ff;
        end
    end
endmodule // wsc_ffc
`default_nettype wire

// [design/wsc_top.sv]
/*
 * wsc_top: setpoint comparison with free-fall compensation, APB slave.
 * Assumes same-clock weights and complete; the four pins are
 * synchronised here.
 */
// Added by the designer: register access over APB and the address map.
// What this block does
// - control word picks simple periodic comparison or start-driven sequence
// - on judged completion after final cut, sample error weight minus final
// - after set count, average, scale, add to free-fall value, restart count
// - only errors within final plus or minus regulation are counted
// - with auto jog in sequence, sample is taken before jogging
// - samples only on judgement; judging interval zero disables compensation
// - rewriting the free-fall value clears sample count and sum
// - coefficient selectable as one, two, three quarters or one
// - cut point triggers at weight at least final minus its set value
// - under below final-under, over above final+over, go in between
// - near zero when weight at most near-zero value, range 0..99999
// - upper limit when weight strictly above its value, range 0..99999
// - lower limit when weight strictly below its value, range 0..99999
// - selectors pick gross, net or off; near zero adds absolute forms
// - limits evaluated always, or outside sequence only while judge input on
// - over/under on always, judge input, completion or hold
// - in sequence, start edge sets all cuts; each clears at threshold
`timescale 1ns/100ps
`default_nettype none
module wsc_top (
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst_n,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // weight source, same clock
    input  wire wsc_pkg::wsc_wt_t   gross_weight,
    input  wire wsc_pkg::wsc_wt_t   net_weight,
    input  wire logic               weight_valid,
    input  wire logic               complete,
    // pins
    input  wire logic               start_pin,
    input  wire logic               stop_pin,
    input  wire logic               judge_pin,
    input  wire logic               hold_pin,
    // flags
    output wsc_pkg::wsc_flags_t     flags
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    wsc_pkg::wsc_ctrl_t  ctrl, next_ctrl;
    wsc_pkg::wsc_wt_t    set_q [wsc_pkg::NSET];
    wsc_pkg::wsc_wt_t    next_set [wsc_pkg::NSET];
    logic [7:0]          avg_count, next_avg_count;
    logic [7:0]          judge_int, next_judge_int;
    logic [7:0]          judge_cnt, next_judge_cnt;
    wsc_pkg::wsc_flags_t next_flags;
    wsc_pkg::wsc_seq_t   seq, next_seq;
    logic                final_done, next_final_done;
    logic [31:0]         next_prdata, rd;
    logic                next_pready, next_pslverr, hit_map;
    logic [3:0]          sync1, sync2;
    logic                start_d, next_start_d;
    logic                ff_write, wr;
    logic [23:0]         ff_value;
    logic [7:0]          ffc_count;
    logic [3:0]          set_idx;
    logic                start_s, stop_s, judge_s, hold_s, start_rise;

    // pin synchronisers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
        end else begin
            sync1 <= {hold_pin, judge_pin, stop_pin, start_pin};
            sync2 <= sync1;
        end
    end
    assign {hold_s, judge_s, stop_s, start_s} = sync2;
    assign start_rise = start_s && !start_d;

    // ------------------------------------------------------------
    // register file and apb
    // ------------------------------------------------------------
    assign wr      = psel && penable && pready && pwrite;
    assign set_idx = 4'((paddr - wsc_pkg::OFS_SET_FIRST) >> 2);
    assign ff_write = wr && paddr == wsc_pkg::OFS_FREE_FALL;

    // read mux and map decode
    always_comb begin
        rd      = 32'h0;
        hit_map = 1'b1;
        if (paddr[1:0] != 2'b00) begin
            hit_map = 1'b0;
        end else if (paddr == wsc_pkg::OFS_CTRL) begin
            rd = 32'(ctrl);
        end else if (paddr >= wsc_pkg::OFS_SET_FIRST && paddr < wsc_pkg::OFS_FREE_FALL) begin
            rd = 32'(set_q[set_idx]);
        end else if (paddr == wsc_pkg::OFS_FREE_FALL) begin
            rd = 32'(signed'(ff_value));
        end else if (paddr == wsc_pkg::OFS_AVG_COUNT) begin
            rd = {24'h0, avg_count};
        end else if (paddr == wsc_pkg::OFS_JUDGE_INT) begin
            rd = {24'h0, judge_int};
        end else if (paddr == wsc_pkg::OFS_STATUS) begin
            // flags, compensation counter, sequence state
            rd = {12'h000, 2'(seq), ffc_count, 10'(flags)};
        end else begin
            hit_map = 1'b0;
        end
    end

    // one wait-free access: answer registered during setup
    always_comb begin
        next_pready    = psel && !penable;
        next_prdata    = (psel && !penable && !pwrite) ? rd : prdata;
        next_pslverr   = psel && !penable && !hit_map;
        next_ctrl      = ctrl;
        next_set       = set_q;
        next_avg_count = avg_count;
        next_judge_int = judge_int;
        if (wr && hit_map) begin
            if (paddr == wsc_pkg::OFS_CTRL) begin
                next_ctrl = wsc_pkg::wsc_ctrl_t'(pwdata[$bits(wsc_pkg::wsc_ctrl_t)-1:0]);
            end else if (paddr >= wsc_pkg::OFS_SET_FIRST && paddr < wsc_pkg::OFS_FREE_FALL) begin
                next_set[set_idx] = pwdata[wsc_pkg::WW-1:0];
                // limit set values clamp to their range
                if ((set_idx == 4'(wsc_pkg::IDX_NZ) || set_idx == 4'(wsc_pkg::IDX_UPPER) ||
                     set_idx == 4'(wsc_pkg::IDX_LOWER)) && pwdata[wsc_pkg::WW-1:0] > wsc_pkg::SET_MAX) begin
                    next_set[set_idx] = wsc_pkg::SET_MAX;
                end
            end else if (paddr == wsc_pkg::OFS_AVG_COUNT) begin
                next_avg_count = pwdata[7:0];
            end else if (paddr == wsc_pkg::OFS_JUDGE_INT) begin
                next_judge_int = pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // comparison
    // ------------------------------------------------------------
    logic signed [25:0] w_ou, w_ul, w_nz, fin;
    logic               hit_c, hit_m, hit_f, ou_on, judged, ul_eval, sample_en;

    always_comb begin
        w_ou = (ctrl.ou_src == wsc_pkg::SRC_NET[1:0]) ? 26'(net_weight) : 26'(gross_weight);
        w_ul = (ctrl.ul_src == wsc_pkg::SRC_NET[1:0]) ? 26'(net_weight) : 26'(gross_weight);
        unique case (ctrl.nz_src)
            wsc_pkg::SRC_NET:       w_nz = 26'(net_weight);
            wsc_pkg::SRC_ABS_GROSS: w_nz = gross_weight[23] ? -26'(gross_weight) : 26'(gross_weight);
            wsc_pkg::SRC_ABS_NET:   w_nz = net_weight[23] ? -26'(net_weight) : 26'(net_weight);
            default:                w_nz = 26'(gross_weight);
        endcase
        ou_on = ctrl.ou_src != wsc_pkg::SRC_OFF[1:0];
        fin   = 26'(set_q[wsc_pkg::IDX_FINAL]);
        // cut thresholds, third uses free-fall value
        hit_c = w_ou >= fin - 26'(set_q[wsc_pkg::IDX_COARSE]);
        hit_m = w_ou >= fin - 26'(set_q[wsc_pkg::IDX_MEDIUM]);
        hit_f = w_ou >= fin - 26'(signed'(ff_value));
    end

    // judging interval counter
    always_comb begin
        next_judge_cnt = judge_cnt;
        judged         = 1'b0;
        // zero interval never judges a completion
        if (complete && judge_int != 8'h00) begin
            if (judge_cnt + 8'h01 >= judge_int) begin
                judged         = 1'b1;
                next_judge_cnt = 8'h00;
            end else begin
                next_judge_cnt = judge_cnt + 8'h01;
            end
        end
    end

    // flags, sequence and final-done tracking
    always_comb begin
        logic ou_evt;
        ou_evt          = 1'b0;
        next_flags      = flags;
        next_seq        = seq;
        next_final_done = final_done;
        next_start_d    = start_s;
        // over/under timing; sequence always judges at completion
        if (ctrl.seq_mode) begin
            ou_evt = judged;
        end else begin
            unique case (ctrl.ou_mode)
                wsc_pkg::OU_ALWAYS:   ou_evt = weight_valid;
                wsc_pkg::OU_JUDGE:    ou_evt = weight_valid && judge_s;
                wsc_pkg::OU_COMPLETE: ou_evt = judged;
                wsc_pkg::OU_HOLD:     ou_evt = weight_valid && hold_s;
            endcase
        end
        if (!ou_on) begin
            next_flags.under = 1'b0;
            next_flags.go    = 1'b0;
            next_flags.over  = 1'b0;
        end else if (ou_evt) begin
            next_flags.under = w_ou < fin - 26'(set_q[wsc_pkg::IDX_UNDER]);
            next_flags.over  = w_ou > fin + 26'(set_q[wsc_pkg::IDX_OVER]);
            next_flags.go    = !(w_ou < fin - 26'(set_q[wsc_pkg::IDX_UNDER])) &&
                               !(w_ou > fin + 26'(set_q[wsc_pkg::IDX_OVER]));
        end
        // limits always or while judge input on
        ul_eval = weight_valid && (ctrl.seq_mode || !ctrl.ul_judge || judge_s);
        if (ctrl.ul_src == wsc_pkg::SRC_OFF[1:0]) begin
            next_flags.upper = 1'b0;
            next_flags.lower = 1'b0;
        end else if (ul_eval) begin
            next_flags.upper = w_ul > 26'(set_q[wsc_pkg::IDX_UPPER]);
            next_flags.lower = w_ul < 26'(set_q[wsc_pkg::IDX_LOWER]);
        end
        if (ctrl.nz_src == wsc_pkg::SRC_OFF) begin
            next_flags.near_zero = 1'b0;
        end else if (weight_valid) begin
            next_flags.near_zero = w_nz <= 26'(set_q[wsc_pkg::IDX_NZ]);
        end
        if (!ctrl.seq_mode) begin
            next_seq = wsc_pkg::SEQ_IDLE;
            next_flags.seq_error = 1'b0;
            if (weight_valid) begin
                next_flags.coarse_cut_point = hit_c;
                next_flags.medium_cut_point = hit_m;
                next_flags.final_cut_point  = hit_f;
            end
        end else begin
            unique case (seq)
                wsc_pkg::SEQ_IDLE: begin
                    if (start_rise && stop_s) begin
                        next_seq = wsc_pkg::SEQ_ERR;
                        next_flags.seq_error = 1'b1;
                    end else if (start_rise) begin
                        next_seq = wsc_pkg::SEQ_RUN;
                        next_flags.coarse_cut_point = 1'b1;
                        next_flags.medium_cut_point = 1'b1;
                        next_flags.final_cut_point  = 1'b1;
                    end
                end
                wsc_pkg::SEQ_RUN: begin
                    // each cut falls at its threshold
                    if (weight_valid && hit_c) next_flags.coarse_cut_point = 1'b0;
                    if (weight_valid && hit_m) next_flags.medium_cut_point = 1'b0;
                    if (weight_valid && hit_f) next_flags.final_cut_point  = 1'b0;
                    if (stop_s || complete) next_seq = wsc_pkg::SEQ_IDLE;
                end
                wsc_pkg::SEQ_ERR: begin
                    // stop clears the error
                    if (stop_s) begin
                        next_seq = wsc_pkg::SEQ_IDLE;
                        next_flags.seq_error = 1'b0;
                    end
                end
            endcase
            if (stop_s) begin
                next_flags.coarse_cut_point = 1'b0;
                next_flags.medium_cut_point = 1'b0;
                next_flags.final_cut_point  = 1'b0;
            end
        end
        // final cut done; set wins over clear
        if (start_rise) next_final_done = 1'b0;
        if (judged) next_final_done = 1'b0;
        if (weight_valid && hit_f) next_final_done = 1'b1;
    end

    // sample at the judged completion, ahead of any jog phase
    // only once the final cut has finished
    assign sample_en = judged && final_done;

    // registers only
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl       <= wsc_pkg::CTRL_RESET;
            set_q      <= '{default: 24'h0};
            avg_count  <= 8'h00;
            judge_int  <= 8'h00;
            judge_cnt  <= 8'h00;
            flags      <= '0;
            seq        <= wsc_pkg::SEQ_IDLE;
            final_done <= 1'b0;
            start_d    <= 1'b0;
            prdata     <= 32'h0;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
        end else begin
            ctrl       <= next_ctrl;
            set_q      <= next_set;
            avg_count  <= next_avg_count;
            judge_int  <= next_judge_int;
            judge_cnt  <= next_judge_cnt;
            flags      <= next_flags;
            seq        <= next_seq;
            final_done <= next_final_done;
            start_d    <= next_start_d;
            prdata     <= next_prdata;
            pready     <= next_pready;
            pslverr    <= next_pslverr;
        end
    end

    // compensation unit
    wsc_ffc u_ffc (
        .clk_sys         (clk_sys),
        .rst_n           (rst_n),
        .sample_en       (sample_en),
        .weight          (wsc_pkg::wsc_wt_t'(w_ou[23:0])),
        .final_target    (set_q[wsc_pkg::IDX_FINAL]),
        .regulation      (set_q[wsc_pkg::IDX_REGUL]),
        .avg_count       (avg_count),
        .coef            (ctrl.coef),
        .ff_write        (ff_write),
        .ff_wdata        (wsc_pkg::wsc_wt_t'(pwdata[23:0])),
        .free_fall_value (ff_value),
        .sample_count    (ffc_count)
    );
endmodule // wsc_top
`default_nettype wire

// [bench/wsc_props.sv]
/* wsc_props: bus and flag checks on wsc_top ports.
   Assumes a master holding each request until pready. */
`timescale 1ns/100ps
`default_nettype none
module wsc_props (
    input wire logic                clk_sys,
    input wire logic                rst_n,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic [7:0]          paddr,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire wsc_pkg::wsc_flags_t flags
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // setup phase of a transfer
    sequence s_setup; psel && !penable; endsequence
    property p_answer; s_setup |=> pready; endproperty
    property p_one; pready |=> !pready; endproperty
    property p_errq; pslverr |-> pready; endproperty
    property p_access; pready |-> psel && penable; endproperty
    property p_align; s_setup ##0 (paddr[1:0] != 2'h0) |=> pslverr; endproperty
    property p_unmap; s_setup ##0 (paddr > 8'h34) |=> pslverr; endproperty
    property p_mapped; s_setup ##0 (paddr <= 8'h34 && paddr[1:0] == 2'h0) |=> !pslverr; endproperty
    property p_judge; $onehot0({flags.under, flags.go, flags.over}); endproperty
    a_answer: assert property (p_answer) else $error("no pready after setup");
    a_one: assert property (p_one) else $error("pready longer than one cycle");
    a_errq: assert property (p_errq) else $error("pslverr without pready");
    a_access: assert property (p_access) else $error("pready outside access");
    a_align: assert property (p_align) else $error("misaligned access accepted");
    a_unmap: assert property (p_unmap) else $error("unmapped access accepted");
    a_mapped: assert property (p_mapped) else $error("mapped access refused");
    a_judge: assert property (p_judge) else $error("two judgement flags");
endmodule // wsc_props
bind wsc_top wsc_props wsc_props_inst (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .flags(flags));
`default_nettype wire

// [bench/wsc_host.sv]
/* wsc_host: host model, an apb master.
   Assumes a slave that answers with pready. */
`timescale 1ns/100ps
`default_nettype none
module wsc_host (
    input  wire logic        clk_sys,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata
);
    logic [31:0] rdata;
    logic        rerr;
    // idle bus
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // one transfer, then an idle edge
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    // unused cuts equal final; nonzero judging interval
    task automatic cfg(input logic [31:0] fin);
        xfer(8'h04, 1'b1, fin);
        xfer(8'h08, 1'b1, fin);
        xfer(8'h0C, 1'b1, fin);
        xfer(8'h30, 1'b1, 32'h1);
    endtask
endmodule // wsc_host
`default_nettype wire

// [bench/testbench.sv]
/* testbench: wsc_top scenarios through the host model.
   Assumes net is gross minus 100; stop, judge, hold stay low. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk_sys = 1'b0, rst_n = 1'b0, weight_valid = 1'b0, complete = 1'b0, start_pin = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    wsc_pkg::wsc_wt_t gross_weight = '0;
    wsc_pkg::wsc_flags_t flags;
    int err_total = 0, compares = 0, cycles = 0;
    always #5 clk_sys = ~clk_sys;
    wsc_host wsc_host_inst (.clk_sys(clk_sys), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    wsc_top wsc_top_inst (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .gross_weight(gross_weight), .net_weight(gross_weight - 24'sd100), .weight_valid(weight_valid),
        .complete(complete), .start_pin(start_pin), .stop_pin(1'b0), .judge_pin(1'b0), .hold_pin(1'b0),
        .flags(flags));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wsc_host_inst.xfer(a, 1'b1, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wsc_host_inst.xfer(a, 1'b0, 32'h0);
        check(wsc_host_inst.rdata, exp);
    endtask
    // expected flags; b: net cuts, abs near zero, limits off
    function automatic wsc_pkg::wsc_flags_t exp_flags(input int g, input logic b);
        wsc_pkg::wsc_flags_t f;
        int w;
        f = '0;
        w = b ? g - 100 : g;
        f.coarse_cut_point = w >= 700;
        f.medium_cut_point = w >= 900;
        f.final_cut_point = w >= 980;
        f.under = w < 990;
        f.over = w > 1010;
        f.go = !f.under && !f.over;
        f.near_zero = ((b && g < 0) ? -g : g) <= 50;
        f.upper = !b && g > 900;
        f.lower = !b && g < 200;
        return f;
    endfunction
    task automatic wt(input int w);
        gross_weight <= 24'(w);
        weight_valid <= 1'b1;
        @(posedge clk_sys);
        weight_valid <= 1'b0;
        @(posedge clk_sys);
    endtask
    // start, weigh, judged completion
    task automatic sample(input int w);
        start_pin <= 1'b1;
        repeat (4) @(posedge clk_sys);
        start_pin <= 1'b0;
        wt(w);
        complete <= 1'b1;
        @(posedge clk_sys);
        complete <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic t_reset();
        rd(8'h00, 32'h0);
        rd(8'h34, 32'h0);
        wsc_host_inst.xfer(8'h40, 1'b0, 32'h0);
        check({31'h0, wsc_host_inst.rerr}, 32'h1);
        wr(8'h05, 32'h1);
        check({31'h0, wsc_host_inst.rerr}, 32'h1);
    endtask
    task automatic t_compare();
        int v[8] = '{1000, 300, 100, 10, 10, 50, 900, 200};
        int ws[19] = '{-60, -5, 40, 51, 199, 200, 800, 900, 901, 979, 980, 989, 990, 1010, 1011, 1089, 1090, 1110, 1111};
        wr(8'h18, 32'h0001_86A0);
        rd(8'h18, 32'h0001_869F);
        foreach (v[i]) wr(8'(4 + 4 * i), 32'(v[i]));
        wr(8'h28, 32'h14);
        for (int b = 0; b < 2; b++) begin
            wr(8'h00, b ? 32'h5A0 : 32'h0);
            foreach (ws[i]) begin
                wt(ws[i]);
                check(32'(flags), 32'(exp_flags(ws[i], b[0])));
            end
        end
    endtask
    task automatic t_comp();
        int q1[4] = '{20050, 20040, 20070, 20080};
        int q2[5] = '{20020, 20000, 20010, 20110, 20010};
        int q3[5] = '{19880, 19990, 20010, 20000, 19980};
        wsc_host_inst.cfg(32'h4E20);
        wr(8'h24, 32'h64);
        wr(8'h2C, 32'h4);
        wr(8'h00, 32'h7);
        sample(20050);
        sample(20040);
        wr(8'h28, 32'h1F4);
        foreach (q1[i]) sample(q1[i]);
        rd(8'h28, 32'h212);
        foreach (q2[i]) sample(q2[i]);
        rd(8'h28, 32'h217);
        foreach (q3[i]) sample(q3[i]);
        rd(8'h28, 32'h214);
    endtask
    task automatic t_coef();
        wr(8'h2C, 32'h1);
        for (int c = 0; c < 4; c++) begin
            wr(8'h00, 32'(4 * c + 1));
            wr(8'h28, 32'h1F4);
            sample(20040);
            rd(8'h28, 32'(500 + 10 * (c + 1)));
        end
        wr(8'h30, 32'h0);
        sample(20040);
        rd(8'h28, 32'h21C);
    endtask
    task automatic report_and_stop();
        if (err_total == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // hang guard, far above the run's length
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            err_total++;
            report_and_stop();
        end
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_compare();
        t_comp();
        t_coef();
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
